/* File: src/irr_top.v */
// isochronous receive readout, capture registers and receive routing control
`timescale 1ns/1ps
`default_nettype none
`include "irr_defines.vh"

module irr_top (
  input  wire        aclk,              // system clock, 40 mhz
  input  wire        aresetn,           // synchronous reset, active low
  input  wire [11:0] s_axi_awaddr,      // write address
  input  wire        s_axi_awvalid,     // write address valid
  output wire        s_axi_awready,     // write address ready
  input  wire [31:0] s_axi_wdata,       // write data
  input  wire [3:0]  s_axi_wstrb,       // write byte strobes
  input  wire        s_axi_wvalid,      // write data valid
  output wire        s_axi_wready,      // write data ready
  output wire [1:0]  s_axi_bresp,       // write response
  output wire        s_axi_bvalid,      // write response valid
  input  wire        s_axi_bready,      // write response ready
  input  wire [11:0] s_axi_araddr,      // read address
  input  wire        s_axi_arvalid,     // read address valid
  output wire        s_axi_arready,     // read address ready
  output wire [31:0] s_axi_rdata,       // read data
  output wire [1:0]  s_axi_rresp,       // read response
  output wire        s_axi_rvalid,      // read data valid
  input  wire        s_axi_rready,      // read data ready
  input  wire [31:0] iso_push_data,     // quadlet from the receive link
  input  wire        iso_push_valid,    // quadlet offered
  output wire        iso_push_ready,    // fifo has room
  input  wire [31:0] hdr_load_data,     // isochronous header quadlet
  input  wire        hdr_load,          // header capture strobe
  input  wire [1:0]  trl_speed,         // speed code of received packet
  input  wire [1:0]  trl_pad_count,     // zero-fill byte count
  input  wire [3:0]  trl_ack_code,      // ack sent by the receiver
  input  wire        trl_load,          // trailer capture strobe
  input  wire        pkt_start,         // async packet header decoded
  input  wire        pkt_broadcast,     // destination is broadcast
  input  wire        pkt_request,       // packet is a request
  input  wire        pkt_write_lock,    // write or lock request
  input  wire        pkt_rom_reg_space, // addressed to rom/register space
  input  wire        pkt_resp_match,    // expected response comparator hit
  input  wire        pkt_selfid,        // self-id packet
  input  wire        pkt_rx_error,      // packet received incorrectly
  input  wire [47:0] pkt_dest_offset,   // destination offset
  output reg         route_valid,       // one-cycle routing decision pulse
  output reg  [1:0]  route_dest,        // chosen destination fifo
  output reg         ack_valid,         // one-cycle ack pulse
  output reg  [3:0]  ack_code,          // ack code to send
  output reg         continuity_check_en, // continuity checking active
  output reg  [7:0]  tag_match_en       // per comparator tag match enable
);

  // ************************************************************
  // registers
  // ************************************************************
  reg  [31:0] route_r;
  reg  [31:0] hdr_r;
  reg  [31:0] trl_r;
  reg  [31:0] last_q_r;
  reg  [31:0] fifo_mem [0:`IRR_FIFO_DEPTH-1];
  reg  [`IRR_FIFO_AW-1:0] wr_ptr_r;
  reg  [`IRR_FIFO_AW-1:0] rd_ptr_r;
  reg  [`IRR_FIFO_AW:0]   count_r;

  reg         aw_got_r;
  reg  [11:0] aw_addr_r;
  reg         w_got_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;

  wire        fifo_empty;
  wire        fifo_full;
  wire        push;
  wire        pop;
  wire        ar_take;
  wire        aw_take;
  wire        w_take;
  wire        aw_have;
  wire        w_have;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        wr_fire;
  wire [31:0] wr_bytes;
  reg  [31:0] rd_data_nxt;
  reg  [1:0]  rd_resp_nxt;
  reg  [1:0]  dest_nxt;
  reg  [3:0]  ack_nxt;

  // ************************************************************
  // bus handshakes
  // ************************************************************
  // one read and one write in flight; ready drops while an answer waits
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign ar_take = s_axi_arvalid & ~rvalid_r;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign aw_have = aw_got_r | aw_take;
  assign w_have  = w_got_r | w_take;
  assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = aw_have & w_have & ~bvalid_r;

  // ************************************************************
  // receive fifo
  // ************************************************************
  assign fifo_empty     = (count_r == {(`IRR_FIFO_AW+1){1'b0}});
  assign fifo_full      = count_r[`IRR_FIFO_AW];
  assign iso_push_ready = ~fifo_full;
  assign push           = iso_push_valid & ~fifo_full;
  // a port read pops only when data is there; an empty read leaves state alone
  assign pop = ar_take & (s_axi_araddr == `IRR_ADDR_ISO_PORT) & ~fifo_empty;

  always @(posedge aclk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= iso_push_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= {`IRR_FIFO_AW{1'b0}};
      rd_ptr_r <= {`IRR_FIFO_AW{1'b0}};
      count_r  <= {(`IRR_FIFO_AW+1){1'b0}};
      last_q_r <= `IRR_QUAD_RST;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        last_q_r <= fifo_mem[rd_ptr_r];
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always @* begin
    rd_data_nxt = 32'h0000_0000;
    rd_resp_nxt = `IRR_RESP_OKAY;
    case (s_axi_araddr)
      `IRR_ADDR_ISO_PORT: begin
        // empty fifo repeats the last quadlet, zero before the first
        rd_data_nxt = fifo_empty ? last_q_r : fifo_mem[rd_ptr_r];
      end
      `IRR_ADDR_HDR_CAPTURE: begin
        rd_data_nxt = hdr_r;
      end
      `IRR_ADDR_TRL_CAPTURE: begin
        rd_data_nxt = trl_r;
      end
      `IRR_ADDR_ROUTE_CTRL: begin
        rd_data_nxt = route_r;
      end
      default: begin
        rd_resp_nxt = `IRR_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `IRR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data_nxt;
      rresp_r  <= rd_resp_nxt;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // write path
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wr_bytes[gi*8 +: 8] = wr_strb[gi] ? wr_data[gi*8 +: 8] : route_r[gi*8 +: 8];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `IRR_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        // the capture registers and the port ignore writes but answer okay
        case (wr_addr)
          `IRR_ADDR_ISO_PORT,
          `IRR_ADDR_HDR_CAPTURE,
          `IRR_ADDR_TRL_CAPTURE,
          `IRR_ADDR_ROUTE_CTRL: begin
            bresp_r <= `IRR_RESP_OKAY;
          end
          default: begin
            bresp_r <= `IRR_RESP_SLVERR;
          end
        endcase
      end else begin
        if (aw_take) begin
          aw_got_r  <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_got_r  <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (bvalid_r & s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // routing control and capture registers
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      route_r <= `IRR_ROUTE_RST;
    end else if (wr_fire & (wr_addr == `IRR_ADDR_ROUTE_CTRL)) begin
      // unused bits stay zero
      route_r <= wr_bytes & `IRR_ROUTE_WMASK;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      hdr_r <= `IRR_QUAD_RST;
      trl_r <= `IRR_QUAD_RST;
    end else begin
      if (hdr_load) begin
        // length 31:16, tag 15:14, channel 13:8, tcode 7:4, sync 3:0
        hdr_r <= hdr_load_data;
      end
      if (trl_load) begin
        trl_r <= 32'h0000_0000;
        trl_r[`IRR_TRL_SPEED_LSB +: 2] <= trl_speed;
        trl_r[`IRR_TRL_PAD_LSB +: 2]   <= trl_pad_count;
        trl_r[`IRR_TRL_ACK_LSB +: 4]   <= trl_ack_code;
      end
    end
  end

  // ************************************************************
  // receive routing decision
  // ************************************************************
  // decided from the register as it stands at header decode, so a later write
  // never retargets a packet already being received
  always @* begin
    dest_nxt = `IRR_DEST_BULK;
    if (pkt_selfid) begin
      dest_nxt = route_r[`IRR_SELFID_DEST_BIT] ? `IRR_DEST_BULK : `IRR_DEST_BROADCAST;
    end else if (pkt_resp_match) begin
      dest_nxt = route_r[`IRR_RESPONSE_DEST_BIT] ? `IRR_DEST_CONTROL : `IRR_DEST_BULK;
    end else begin
      case ({route_r[`IRR_ASYNC_DEST_HI_BIT], route_r[`IRR_ASYNC_DEST_LO_BIT]})
        2'h0: begin
          dest_nxt = pkt_broadcast ? `IRR_DEST_BROADCAST : `IRR_DEST_CONTROL;
        end
        2'h1: begin
          if (pkt_rom_reg_space & pkt_request & pkt_broadcast) begin
            dest_nxt = `IRR_DEST_BROADCAST;
          end else if (pkt_rom_reg_space & pkt_write_lock & ~pkt_broadcast) begin
            dest_nxt = `IRR_DEST_CONTROL;
          end else begin
            dest_nxt = `IRR_DEST_BULK;
          end
        end
        2'h2: begin
          dest_nxt = `IRR_DEST_BULK;
        end
        2'h3: begin
          if (pkt_request & pkt_dest_offset[`IRR_UPPER_HALF_BIT]) begin
            dest_nxt = pkt_broadcast ? `IRR_DEST_BROADCAST : `IRR_DEST_CONTROL;
          end else begin
            dest_nxt = `IRR_DEST_BULK;
          end
        end
        default: begin
          dest_nxt = `IRR_DEST_BULK;
        end
      endcase
    end
  end

  always @* begin
    if (pkt_rx_error) begin
      ack_nxt = `IRR_ACK_DATA_ERROR;
    end else if (pkt_write_lock & route_r[`IRR_ACK_PENDING_POLICY_BIT]) begin
      ack_nxt = `IRR_ACK_PENDING;
    end else begin
      ack_nxt = `IRR_ACK_COMPLETE;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      route_valid         <= 1'b0;
      route_dest          <= `IRR_DEST_BULK;
      ack_valid           <= 1'b0;
      ack_code            <= `IRR_ACK_COMPLETE;
      continuity_check_en <= 1'b1;
    end else begin
      route_valid <= pkt_start;
      // broadcast packets are never acknowledged on the bus
      ack_valid   <= pkt_start & ~pkt_broadcast;
      if (pkt_start) begin
        route_dest          <= dest_nxt;
        ack_code            <= ack_nxt;
        continuity_check_en <= ~route_r[`IRR_CONTINUITY_DISABLE_BIT];
      end
    end
  end

  // ************************************************************
  // transport-stream tag match enables
  // ************************************************************
  // comparator k sits at bit 7-k since the register counts from the msb
  generate
    for (gi = 0; gi < `IRR_TAG_MATCH_N; gi = gi + 1) begin : g_tag
      always @(posedge aclk) begin
        if (!aresetn) begin
          tag_match_en[gi] <= 1'b0;
        end else if (pkt_start) begin
          tag_match_en[gi] <= route_r[`IRR_TAG_MATCH_MSB - gi];
        end
      end
    end
  endgenerate

endmodule // irr_top

`default_nettype wire

/* File: inc/irr_defines.vh */
// constants for the isochronous receive readout and routing register block
`ifndef IRR_DEFINES_VH
`define IRR_DEFINES_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define IRR_ADDR_W            12
`define IRR_ADDR_ISO_PORT     12'h13c
`define IRR_ADDR_HDR_CAPTURE  12'h140
`define IRR_ADDR_TRL_CAPTURE  12'h144
`define IRR_ADDR_ROUTE_CTRL   12'h148

// ************************************************************
// reset values and writable masks
// ************************************************************
`define IRR_QUAD_RST          32'h0000_0000
`define IRR_ROUTE_RST         32'h0000_4000
`define IRR_ROUTE_WMASK       32'h0000_5fff

// ************************************************************
// routing control fields (bit 00 is the msb, so doc bit n is bit 31-n)
// ************************************************************
`define IRR_ACK_PENDING_POLICY_BIT   14
`define IRR_CONTINUITY_DISABLE_BIT   12
`define IRR_RESPONSE_DEST_BIT        11
`define IRR_SELFID_DEST_BIT          10
`define IRR_ASYNC_DEST_LO_BIT        9
`define IRR_ASYNC_DEST_HI_BIT        8
`define IRR_TAG_MATCH_MSB            7
`define IRR_TAG_MATCH_N              8

// ************************************************************
// trailer capture fields
// ************************************************************
`define IRR_TRL_SPEED_LSB     16
`define IRR_TRL_PAD_LSB       8
`define IRR_TRL_ACK_LSB       0

// ************************************************************
// acknowledge codes and destination encodings
// ************************************************************
`define IRR_ACK_COMPLETE      4'h1
`define IRR_ACK_PENDING       4'h2
`define IRR_ACK_DATA_ERROR    4'hd
`define IRR_DEST_CONTROL      2'h0
`define IRR_DEST_BROADCAST    2'h1
`define IRR_DEST_BULK         2'h2
`define IRR_UPPER_HALF_BIT    47

// ************************************************************
// receive fifo and bus answers
// ************************************************************
`define IRR_FIFO_DEPTH        16
`define IRR_FIFO_AW           4
`define IRR_RESP_OKAY         2'h0
`define IRR_RESP_SLVERR       2'h2

`endif

/* File: test/irr_top_checker.sv */
// concurrent checks on the ports of the receive readout and routing block
`timescale 1ns/1ps
`default_nettype none
module irr_top_checker (
  input wire logic        aclk,                // clock
  input wire logic        aresetn,             // reset, active low
  input wire logic        s_axi_arvalid,       // read address valid
  input wire logic        s_axi_arready,       // read address ready
  input wire logic [31:0] s_axi_rdata,         // read data
  input wire logic        s_axi_rvalid,        // read data valid
  input wire logic        s_axi_rready,        // read data ready
  input wire logic        s_axi_bvalid,        // write response valid
  input wire logic        s_axi_bready,        // write response ready
  input wire logic        pkt_start,           // packet decoded
  input wire logic        pkt_broadcast,       // broadcast packet
  input wire logic        pkt_resp_match,      // response comparator hit
  input wire logic        pkt_selfid,          // self-id packet
  input wire logic        pkt_rx_error,        // bad packet
  input wire logic        route_valid,         // routing pulse
  input wire logic [1:0]  route_dest,          // destination fifo
  input wire logic        ack_valid,           // ack pulse
  input wire logic [3:0]  ack_code,            // ack code
  input wire logic        continuity_check_en, // continuity check on
  input wire logic [7:0]  tag_match_en         // tag match enables
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_wait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_bad_pkt; pkt_start && pkt_rx_error && !pkt_broadcast; endsequence

  AST_READ_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read taken without data next cycle");
  AST_READ_HOLD: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before taken");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  AST_ROUTE_PULSE: assert property (pkt_start |=> route_valid)
    else $error("no routing pulse after packet start");
  AST_ROUTE_QUIET: assert property (!pkt_start |=> !route_valid ##0 $stable(route_dest))
    else $error("routing output moved without packet start");
  AST_ACK_ERROR: assert property (s_bad_pkt |=> ack_valid && ack_code == 4'hd)
    else $error("bad packet not answered with data error");
  AST_ACK_CODES: assert property (ack_valid |-> ack_code inside {4'h1, 4'h2, 4'hd})
    else $error("ack code outside the sent set");
  AST_SELFID: assert property (pkt_start && pkt_selfid |=> route_dest inside {2'h1, 2'h2})
    else $error("self-id routed to wrong fifo");
  AST_RESP: assert property (pkt_start && pkt_resp_match && !pkt_selfid
                             |=> route_dest inside {2'h0, 2'h2})
    else $error("matched response routed to wrong fifo");
  AST_RESET_OUT: assert property ($rose(aresetn) |-> continuity_check_en
                                  && tag_match_en == 8'h00 && !route_valid)
    else $error("routing outputs wrong after reset");
endmodule // irr_top_checker

bind irr_top irr_top_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .pkt_start(pkt_start), .pkt_broadcast(pkt_broadcast), .pkt_resp_match(pkt_resp_match),
  .pkt_selfid(pkt_selfid), .pkt_rx_error(pkt_rx_error), .route_valid(route_valid),
  .route_dest(route_dest), .ack_valid(ack_valid), .ack_code(ack_code),
  .continuity_check_en(continuity_check_en), .tag_match_en(tag_match_en)
);
`default_nettype wire

/* File: test/irr_link_model.sv */
// receive link side model: pushes quadlets, loads captures, announces packets
`timescale 1ns/1ps
`default_nettype none
module irr_link_model (
  input  wire logic        aclk,            // clock
  input  wire logic        iso_push_ready,  // fifo has room
  output var  logic [31:0] iso_push_data,   // quadlet
  output var  logic        iso_push_valid,  // quadlet offered
  output var  logic [31:0] hdr_load_data,   // header quadlet
  output var  logic        hdr_load,        // header strobe
  output var  logic [7:0]  trl_fields,      // speed, pad count, ack code
  output var  logic        trl_load,        // trailer strobe
  output var  logic        pkt_start,       // packet decoded
  output var  logic [6:0]  pkt_flags,       // bc req wl rom resp sid err
  output var  logic [47:0] pkt_dest_offset  // destination offset
);
  // released lines show the inverse so stale values are never mistaken for live ones
  initial begin
    {iso_push_data, iso_push_valid, hdr_load_data, hdr_load, trl_fields} = '0;
    {trl_load, pkt_start, pkt_flags, pkt_dest_offset} = '0;
  end
  task push(input logic [31:0] d);
    @(posedge aclk);
    iso_push_data  <= d;
    iso_push_valid <= 1'b1;
    do @(posedge aclk); while (iso_push_ready !== 1'b1);
    iso_push_valid <= 1'b0;
    iso_push_data  <= ~d;
  endtask
  task hdr(input logic [31:0] d);
    @(posedge aclk);
    hdr_load_data <= d;
    hdr_load      <= 1'b1;
    @(posedge aclk);
    hdr_load      <= 1'b0;
    hdr_load_data <= ~d;
  endtask
  task trl(input logic [7:0] f);
    @(posedge aclk);
    trl_fields <= f;
    trl_load   <= 1'b1;
    @(posedge aclk);
    trl_load   <= 1'b0;
    trl_fields <= ~f;
  endtask
  task pkt(input logic [6:0] f, input logic [47:0] o);
    @(posedge aclk);
    pkt_start       <= 1'b1;
    pkt_flags       <= f;
    pkt_dest_offset <= o;
    @(posedge aclk);
    pkt_start       <= 1'b0;
    pkt_flags       <= ~f;
    pkt_dest_offset <= ~o;
  endtask
endmodule // irr_link_model
`default_nettype wire

/* File: test/iso_rx_readout_and_routing_test.sv */
// register and routing tests for the receive readout block
`timescale 1ns/1ps
`default_nettype none
`include "irr_defines.vh"
module iso_rx_readout_and_routing_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, route_dest;
  wire  [31:0] s_axi_rdata, iso_push_data, hdr_load_data;
  wire         iso_push_valid, iso_push_ready, hdr_load, trl_load, pkt_start;
  wire         route_valid, ack_valid, continuity_check_en;
  wire  [3:0]  ack_code;
  wire  [7:0]  trl_fields, tag_match_en;
  wire  [6:0]  pf;
  wire  [47:0] pkt_dest_offset;
  int          n_mismatch, checks, cyc, i;
  logic [3:0]  acks [5] = '{4'h1, 4'h2, 4'h4, 4'hd, 4'he};

  irr_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .iso_push_data(iso_push_data), .iso_push_valid(iso_push_valid),
    .iso_push_ready(iso_push_ready), .hdr_load_data(hdr_load_data), .hdr_load(hdr_load),
    .trl_speed(trl_fields[7:6]), .trl_pad_count(trl_fields[5:4]),
    .trl_ack_code(trl_fields[3:0]), .trl_load(trl_load), .pkt_start(pkt_start),
    .pkt_broadcast(pf[6]), .pkt_request(pf[5]), .pkt_write_lock(pf[4]),
    .pkt_rom_reg_space(pf[3]), .pkt_resp_match(pf[2]), .pkt_selfid(pf[1]),
    .pkt_rx_error(pf[0]), .pkt_dest_offset(pkt_dest_offset), .route_valid(route_valid),
    .route_dest(route_dest), .ack_valid(ack_valid), .ack_code(ack_code),
    .continuity_check_en(continuity_check_en), .tag_match_en(tag_match_en)
  );
  irr_link_model lnk (
    .aclk(aclk), .iso_push_ready(iso_push_ready), .iso_push_data(iso_push_data),
    .iso_push_valid(iso_push_valid), .hdr_load_data(hdr_load_data), .hdr_load(hdr_load),
    .trl_fields(trl_fields), .trl_load(trl_load), .pkt_start(pkt_start), .pkt_flags(pf),
    .pkt_dest_offset(pkt_dest_offset)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // the ceiling sits far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task final_report();
    $display("compares %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rc(input string n, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, rdv);
  endtask
  task pk(input logic [6:0] f, input logic [47:0] o, input logic [1:0] d, input logic av,
          input logic [3:0] ac);
    lnk.pkt(f, o);
    #1;
    chk("route_valid", 32'h1, {31'h0, route_valid});
    chk("route_dest", {30'h0, d}, {30'h0, route_dest});
    chk("ack_valid", {31'h0, av}, {31'h0, ack_valid});
    if (av) chk("ack_code", {28'h0, ac}, {28'h0, ack_code});
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc("port", `IRR_ADDR_ISO_PORT, 32'h0);
    rc("header", `IRR_ADDR_HDR_CAPTURE, 32'h0);
    rc("trailer", `IRR_ADDR_TRL_CAPTURE, 32'h0);
    rc("routing", `IRR_ADDR_ROUTE_CTRL, 32'h0000_4000);
    rd(12'h14c);
    chk("unmapped resp", 32'h2, {30'h0, rsp});
    chk("unmapped data", 32'h0, rdv);
    wr(12'h14c, 32'h0);
    chk("unmapped wr resp", 32'h2, {30'h0, rsp});
    $display("test reset values done");
    lnk.push(32'h8000_0001);
    lnk.push(32'h1234_5678);
    lnk.push(32'hfedc_ba98);
    rc("pop0", `IRR_ADDR_ISO_PORT, 32'h8000_0001);
    rc("pop1", `IRR_ADDR_ISO_PORT, 32'h1234_5678);
    rc("pop2", `IRR_ADDR_ISO_PORT, 32'hfedc_ba98);
    rc("empty0", `IRR_ADDR_ISO_PORT, 32'hfedc_ba98);
    rc("empty1", `IRR_ADDR_ISO_PORT, 32'hfedc_ba98);
    $display("test fifo port done");
    lnk.hdr(32'hc0a1_5f3c);
    rc("header", `IRR_ADDR_HDR_CAPTURE, 32'hc0a1_5f3c);
    wr(`IRR_ADDR_HDR_CAPTURE, 32'hffff_ffff);
    chk("header wr resp", 32'h0, {30'h0, rsp});
    rc("header ro", `IRR_ADDR_HDR_CAPTURE, 32'hc0a1_5f3c);
    for (i = 0; i < 5; i++) begin
      lnk.trl({i[1:0], 2'(3 - i), acks[i]});
      rc("trailer", `IRR_ADDR_TRL_CAPTURE, {14'h0, i[1:0], 6'h0, 2'(3 - i), 4'h0, acks[i]});
    end
    wr(`IRR_ADDR_TRL_CAPTURE, 32'h0);
    rc("trailer ro", `IRR_ADDR_TRL_CAPTURE, {14'h0, 2'h0, 6'h0, 2'h3, 4'h0, 4'he});
    $display("test captures done");
    wr(`IRR_ADDR_ROUTE_CTRL, 32'hffff_ffff);
    rc("routing rw", `IRR_ADDR_ROUTE_CTRL, 32'h0000_5fff);
    chk("tag before pkt", 32'h0, {24'h0, tag_match_en});
    pk(7'h00, 48'h0, 2'h2, 1'b1, 4'h1);
    chk("tag all", 32'hff, {24'h0, tag_match_en});
    chk("cont off", 32'h0, {31'h0, continuity_check_en});
    wr(`IRR_ADDR_ROUTE_CTRL, 32'h0000_0001);
    pk(7'h00, 48'h0, 2'h0, 1'b1, 4'h1);
    chk("tag 7", 32'h80, {24'h0, tag_match_en});
    chk("cont on", 32'h1, {31'h0, continuity_check_en});
    for (i = 0; i < 4; i++) begin
      wr(`IRR_ADDR_ROUTE_CTRL, {17'h0, i[0], 4'h0, i[0], i[1], 8'h0});
      pk(7'b0111000, 48'h0, i[1] ? 2'h2 : 2'h0, 1'b1, i[0] ? 4'h2 : 4'h1);
      pk(7'b1100000, 48'h8000_0000_0000, (i[0] ^ i[1]) ? 2'h2 : 2'h1, 1'b0, 4'h0);
    end
    pk(7'b0111001, 48'h0, 2'h2, 1'b1, 4'hd);
    for (i = 0; i < 2; i++) begin
      wr(`IRR_ADDR_ROUTE_CTRL, {20'h0, i[0], i[0], 10'h0});
      pk(7'b0000010, 48'h0, i[0] ? 2'h2 : 2'h1, 1'b1, 4'h1);
      pk(7'b0100100, 48'h0, i[0] ? 2'h0 : 2'h2, 1'b1, 4'h1);
    end
    $display("test routing done");
    final_report();
  end
endmodule // iso_rx_readout_and_routing_test
`default_nettype wire
